/* File: flash_program_erase_control.sv */
// flash_program_erase_control: flash module controller top
// assumes: cpu repeats a fetch after o_stall falls; timing clocks
// slower than i_clk so an erase sweep ends inside its pulse
`timescale 1ns/10ps
module flash_program_erase_control (
  input  wire logic                    i_clk,        // 25 MHz clock
  input  wire logic                    i_rst_b,      // async reset, low
  input  wire logic [1:0]              i_reg_addr,   // register index
  input  wire logic [7:0]              i_reg_wdata,  // register data in
  input  wire logic                    i_reg_wr,     // register write
  input  wire logic                    i_reg_rd,     // register read
  output logic      [7:0]              o_reg_rdata,  // data, next cycle
  input  wire logic [flash_pkg::AW-1:0] i_mab,       // byte address
  input  wire logic [15:0]             i_mdb_wdata,  // memory data in
  input  wire logic                    i_mem_rd,     // memory read
  input  wire logic                    i_mem_wr,     // memory write
  input  wire logic                    i_mem_byte,   // byte access
  input  wire logic                    i_mem_fetch,  // read is a fetch
  output logic      [15:0]             o_mdb_rdata,  // memory data out
  output logic                         o_stall,      // hold execution
  output logic                         o_detached,   // off the buses
  output logic                         o_busy,       // operation running
  output logic                         o_wait,       // block word done
  output logic                         o_nmi_req,    // violation pulse
  input  wire logic                    i_aux_clk,    // auxiliary clock
  input  wire logic                    i_main_clk,   // main clock
  input  wire logic                    i_submain_clk // submain clock
);
  import flash_pkg::*;

  typedef struct packed {
    logic [7:0]    c1;
    logic [7:0]    c2;
    logic          lock;
    logic          ie;
    logic          viol;
    op_t           op;
    logic [AW-1:0] laddr;
    logic [15:0]   ldata;
    logic [WW-1:0] sweep;
    logic [WW-1:0] send;
    logic          sweeping;
    logic          go;
    logic          next;
    logic          stop;
    logic          abort;
    logic [7:0]    rdata;
    logic [15:0]   mdata;
    logic          stall;
    logic          busy;
    logic          waitf;
    logic          nmi;
  } st_t;

  st_t          q, d;
  flash_core_if core ();
  logic         active;
  logic         running;
  logic         hold_st;
  logic         in_sec;
  logic         good_wr;
  logic         bad_wr;
  logic         wr_next;
  logic         rd_bad;
  logic         fetch_hold;
  logic [3:0]   mode;
  logic [7:0]   v3;

  // ------------------------------------------------------------
  // sub-blocks
  // ------------------------------------------------------------
  flash_tgen u_tgen (
    .i_clk         (i_clk),
    .i_rst_b       (i_rst_b),
    .i_aux_clk     (i_aux_clk),
    .i_main_clk    (i_main_clk),
    .i_submain_clk (i_submain_clk),
    .tg            (core.tgen)
  );

  flash_array #(
    .WORDS (1 << WW)
  ) u_array (
    .i_clk (i_clk),
    .ar    (core.arr)
  );

  // byte data goes to its lane, the other lane stays erased
  function automatic logic [15:0] lane(input logic [15:0] w,
                                       input logic        b,
                                       input logic        hi);
    if (!b) lane = w;
    else if (hi) lane = {w[7:0], ERASED[7:0]};
    else lane = {ERASED[7:0], w[7:0]};
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    d = q;
    d.go = 1'b0;
    d.next = 1'b0;
    d.stop = 1'b0;
    d.abort = 1'b0;
    d.nmi = 1'b0;
    d.rdata = 8'h00;
    active = (q.op != OP_IDLE);
    running = (core.st != TG_OFF);
    hold_st = (q.op == OP_BLK) && (core.st == TG_HOLD);
    mode = {q.c1[C1_BLK], q.c1[C1_PROG], q.c1[C1_MASS], q.c1[C1_ERASE]};
    in_sec = (i_mab[AW-1:SEC_BBITS] == q.laddr[AW-1:SEC_BBITS]);

    // memory write decode; software must not touch a busy module
    wr_next = 1'b0;
    good_wr = 1'b0;
    bad_wr = 1'b0;
    if (i_mem_wr) begin
      if (hold_st && q.c1[C1_BLK] && in_sec && !q.next) begin
        wr_next = 1'b1;
      end else if (active || q.lock) begin
        bad_wr = 1'b1;
      end else if (mode inside {M_PROG, M_BLK, M_SEG, M_MAIN, M_ALL}) begin
        good_wr = 1'b1;
      end else begin
        bad_wr = 1'b1;
      end
    end

    // reads of a busy module: fetches stall, data reads violate; in block mode fetches violate, and data reads do too except in the hold
    if (hold_st) rd_bad = i_mem_rd && i_mem_fetch;
    else rd_bad = i_mem_rd && active
                  && ((q.op == OP_BLK) || !i_mem_fetch);
    fetch_hold = i_mem_rd && i_mem_fetch && active
                 && (q.op != OP_BLK);

    // start: latch address and data; a block's next word reloads them
    if (good_wr) begin
      d.laddr = i_mab;
      d.ldata = lane(i_mdb_wdata, i_mem_byte, i_mab[0]);
      d.go = 1'b1;
      unique case (mode)
        M_PROG: d.op = OP_PROG;
        M_BLK:  d.op = OP_BLK;
        M_SEG: begin
          d.op = OP_ERASE;
          d.sweep = {i_mab[AW-1 -: SEGB], {SEG_WBITS{1'b0}}};
          d.send = {i_mab[AW-1 -: SEGB], {SEG_WBITS{1'b1}}};
        end
        M_MAIN: begin
          d.op = OP_ERASE;
          d.sweep = '0;
          d.send = MAIN_LAST;
        end
        default: begin
          d.op = OP_ERASE;
          d.sweep = '0;
          d.send = '1;
        end
      endcase
    end

    // next word of a block reuses the latches, voltage stays up
    if (wr_next) begin
      d.laddr = i_mab;
      d.ldata = lane(i_mdb_wdata, i_mem_byte, i_mab[0]);
      d.next = 1'b1;
    end
    if (hold_st && !q.c1[C1_BLK]) d.stop = 1'b1;

    // erase walks its range one word a clock, whole segments only
    if (core.pulse_go && (q.op == OP_ERASE)) d.sweeping = 1'b1;
    if (q.sweeping) begin
      if (q.sweep == q.send) d.sweeping = 1'b0;
      else d.sweep = WW'(q.sweep + 1'b1);
    end

    // back to read mode once the generator has switched off
    if (active && !running && !q.go && !q.sweeping && !core.pulse_go) begin
      d.op = OP_IDLE;
    end

    // register writes; the divider is frozen while busy
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        REG_CTL_ONE: d.c1 = i_reg_wdata & C1_MASK;
        REG_CTL_TWO: if (!active) d.c2 = i_reg_wdata;
        REG_CTL_THREE: begin
          d.lock = i_reg_wdata[C3_LOCK];
          d.ie = i_reg_wdata[C3_IE];
          if (!i_reg_wdata[C3_VIOL]) d.viol = 1'b0;
          d.abort = i_reg_wdata[C3_EMERGENCY_ABORT_BIT];
        end
        default: ;
      endcase
    end

    // flag set after the clear so a same-cycle event is kept
    if (bad_wr || rd_bad) begin
      d.viol = 1'b1;
      d.nmi = q.ie;
    end

    // emergency exit: cut the operation, contents may be marginal
    if (q.abort) begin
      d.op = OP_IDLE;
      d.sweeping = 1'b0;
      d.go = 1'b0;
      d.next = 1'b0;
    end

    // register read, answered in the following cycle
    v3 = 8'h00;
    v3[C3_BUSY] = active;
    v3[C3_VIOL] = q.viol;
    v3[C3_WAIT] = hold_st;
    v3[C3_LOCK] = q.lock;
    v3[C3_IE] = q.ie;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        REG_CTL_ONE:   d.rdata = q.c1;
        REG_CTL_TWO:   d.rdata = q.c2;
        REG_CTL_THREE: d.rdata = v3;
        default:       d.rdata = 8'h00;
      endcase
    end

    // memory read: a busy module answers with a jump-to-self word
    if (i_mem_rd) begin
      d.mdata = active ? BUSY_READ : core.rdata;
    end
    d.stall = (q.stall || fetch_hold) && (d.op != OP_IDLE);
    d.busy = (d.op != OP_IDLE);
    d.waitf = (d.op == OP_BLK) && (core.st == TG_HOLD);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '0;
      q.c2 <= C2_RST;
      q.lock <= LOCK_RST;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // core drive: transparent address in read mode, sweep counter during the erase sweep, latches else
  // ------------------------------------------------------------
  always_comb begin
    if (q.sweeping) core.addr = q.sweep;
    else if (active) core.addr = q.laddr[AW-1:1];
    else core.addr = i_mab[AW-1:1];
    core.we = q.sweeping
              || (core.pulse_go && (q.op inside {OP_PROG, OP_BLK}));
    core.erase = q.sweeping;
    core.wdata = q.ldata;
    core.go = q.go;
    core.next = q.next;
    core.stop = q.stop;
    core.abort = q.abort;
    core.hold = (q.op == OP_BLK) && q.c1[C1_BLK];
    core.ctl_two = q.c2;
    unique case (q.op)
      OP_ERASE: core.plen = T_ERASE;
      OP_BLK:   core.plen = T_BLK;
      default:  core.plen = T_PROG;
    endcase
  end

  // outputs straight from the state register
  assign o_reg_rdata = q.rdata;
  assign o_mdb_rdata = q.mdata;
  assign o_stall     = q.stall;
  assign o_detached  = q.busy;
  assign o_busy      = q.busy;
  assign o_wait      = q.waitf;
  assign o_nmi_req   = q.nmi;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_start;
    good_wr ##1 q.go;
  endsequence

  sequence s_bad_access;
    bad_wr || rd_bad;
  endsequence

  chk_start_ramp: assert property (
    s_start |=> (core.st == TG_RAMP))
    else $error("start did not enter ramp phase");

  chk_busy_read: assert property (
    i_mem_rd && active |=> (o_mdb_rdata == BUSY_READ))
    else $error("busy module returned array data");

  chk_fetch_stall: assert property (
    fetch_hold && (d.op != OP_IDLE) |=> o_stall && o_detached)
    else $error("fetch on busy module not stalled");

  chk_stall_release: assert property (
    $fell(o_busy) |-> !o_stall)
    else $error("stall held after busy fell");

  chk_latch_hold: assert property (
    active && !wr_next && !q.abort |=> $stable(q.laddr) && $stable(q.ldata))
    else $error("latches moved during operation");

  chk_idle_quiet: assert property (
    (q.op == OP_IDLE) && !q.go |-> (core.st == TG_OFF) && !core.we)
    else $error("generator active in read mode");

  chk_busy_flag: assert property (
    running && !q.abort |=> o_busy)
    else $error("busy low while generator runs");

  chk_viol_nmi: assert property (
    s_bad_access ##0 q.ie |=> q.viol && o_nmi_req)
    else $error("violation not flagged");

  chk_abort_stop: assert property (
    q.abort |=> (core.st == TG_OFF) && (q.op == OP_IDLE) && !q.sweeping)
    else $error("abort did not stop operation");

  chk_sweep_end: assert property (
    q.sweeping && (q.sweep == q.send) && !q.abort |=> !q.sweeping)
    else $error("erase sweep ran past range");

  chk_block_sec: assert property (
    i_mem_wr && hold_st && !in_sec |=> q.viol && !q.next)
    else $error("block write outside section accepted");
endmodule // flash_program_erase_control

/* File: flash_pkg.sv */
// flash_pkg: shared constants and types of the flash controller
// assumes: imported by the controller, timing generator and array
package flash_pkg;
  localparam int          AW        = 10;  // byte address bits
  localparam int          WW        = AW - 1; // word index bits
  localparam int          SEG_WBITS = 6;   // 64 words, 128 bytes
  localparam int          SEGB      = WW - SEG_WBITS; // segment index
  localparam int          SEC_BBITS = 6;   // 64-byte block section
  localparam int          MAIN_SEGS = 6;   // main segments 0..5
  localparam logic [WW-1:0] MAIN_LAST =
    WW'(MAIN_SEGS * (1 << SEG_WBITS) - 1);
  // register indices
  localparam logic [1:0]  REG_CTL_ONE   = 2'h0;
  localparam logic [1:0]  REG_CTL_TWO   = 2'h1;
  localparam logic [1:0]  REG_CTL_THREE = 2'h2;
  // flash_control_reg_one fields
  localparam int          C1_ERASE  = 1;
  localparam int          C1_MASS   = 2;
  localparam int          C1_PROG   = 6;
  localparam int          C1_BLK    = 7;
  localparam logic [7:0]  C1_MASK   = 8'hC6;
  // flash_control_reg_two fields
  localparam int          DIVW      = 6;
  localparam int          C2_SEL    = 6;
  localparam logic [7:0]  C2_RST    = 8'h42;
  // flash_control_reg_three fields
  localparam int          C3_BUSY   = 0;
  localparam int          C3_VIOL   = 2;
  localparam int          C3_WAIT   = 3;
  localparam int          C3_LOCK   = 4;
  localparam int          C3_EMERGENCY_ABORT_BIT   = 5;
  localparam int          C3_IE     = 6;
  localparam logic        LOCK_RST  = 1'b1;
  // mode codes {block, program, mass, erase}
  localparam logic [3:0]  M_PROG    = 4'h4;
  localparam logic [3:0]  M_BLK     = 4'hC;
  localparam logic [3:0]  M_SEG     = 4'h1;
  localparam logic [3:0]  M_MAIN    = 4'h2;
  localparam logic [3:0]  M_ALL     = 4'h3;
  // phase lengths in timing generator clocks
  localparam logic [7:0]  T_RAMP    = 8'h04;
  localparam logic [7:0]  T_PROG    = 8'h1E;
  localparam logic [7:0]  T_BLK     = 8'h0F;
  localparam logic [7:0]  T_ERASE   = 8'hF0;
  localparam logic [7:0]  T_OFF     = 8'h04;
  localparam logic [15:0] ERASED    = 16'hFFFF;
  localparam logic [15:0] BUSY_READ = 16'h3FFF;
  typedef enum logic [1:0] {
    OP_IDLE = 2'h0, OP_PROG = 2'h1, OP_BLK = 2'h3, OP_ERASE = 2'h2
  } op_t;
  typedef enum logic [2:0] {
    TG_OFF = 3'h0, TG_RAMP = 3'h1, TG_PULSE = 3'h3,
    TG_HOLD = 3'h2, TG_FALL = 3'h6
  } tg_t;
endpackage

/* File: flash_core_if.sv */
// flash_core_if: controller to timing generator and array
// assumes: all signals on the system clock
`timescale 1ns/10ps
interface flash_core_if;
  import flash_pkg::*;
  logic          go, next, stop, abort, hold, pulse_go;
  logic [7:0]    plen;
  logic [7:0]    ctl_two;
  tg_t           st;
  logic [WW-1:0] addr;
  logic          we, erase;
  logic [15:0]   wdata, rdata;
  modport ctl  (output go, next, stop, abort, hold, plen, ctl_two,
                output addr, we, erase, wdata,
                input st, pulse_go, rdata);
  modport tgen (input go, next, stop, abort, hold, plen, ctl_two,
                output st, pulse_go);
  modport arr  (input addr, we, erase, wdata, output rdata);
endinterface // flash_core_if

/* File: flash_array.sv */
// flash_array: word array, erase to ones, program clears bits
// assumes: one operation per cycle, addressed by the controller
`timescale 1ns/10ps
module flash_array #(
  parameter int WORDS = 512               // words in the module
) (
  input  wire logic  i_clk,               // system clock
  flash_core_if.arr  ar                   // array port
);
  import flash_pkg::*;
  logic [15:0] mem [0:WORDS-1];
  // no reset: contents survive like real cells
  always_ff @(posedge i_clk) begin
    if (ar.we) begin
      mem[ar.addr] <= ar.erase ? ERASED : (mem[ar.addr] & ar.wdata);
    end
  end
  assign ar.rdata = mem[ar.addr];
endmodule // flash_array

/* File: flash_tgen.sv */
// flash_tgen: clock select, divider and three-phase sequencer
// assumes: selected clock much slower than i_clk and kept stable
`timescale 1ns/10ps
module flash_tgen (
  input  wire logic  i_clk,               // system clock
  input  wire logic  i_rst_b,             // async reset, low
  input  wire logic  i_aux_clk,           // auxiliary clock
  input  wire logic  i_main_clk,          // main clock
  input  wire logic  i_submain_clk,       // submain clock
  flash_core_if.tgen tg                   // controller side
);
  import flash_pkg::*;
  typedef struct packed {
    logic [2:0]      s1;
    logic [2:0]      s2;
    logic            last;
    logic [DIVW-1:0] dcnt;
    logic [7:0]      cnt;
    tg_t             st;
    logic            pgo;
  } tgs_t;
  tgs_t       q, d;
  logic [1:0] idx;
  logic       edge_s, tick, done;
  logic [7:0] lim;
  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    d = q;
    d.s1 = {i_submain_clk, i_main_clk, i_aux_clk};
    d.s2 = q.s1;
    idx = tg.ctl_two[C2_SEL+1] ? 2'h2 : {1'b0, tg.ctl_two[C2_SEL]};
    d.last = q.s2[idx];
    edge_s = q.s2[idx] && !q.last;
    // divider stops in read mode; a changed ratio mid-run is not caught
    tick = edge_s && (q.dcnt == tg.ctl_two[DIVW-1:0]);
    if (q.st == TG_OFF) begin
      d.dcnt = '0;
    end else if (edge_s) begin
      d.dcnt = tick ? '0 : DIVW'(q.dcnt + 1'b1);
    end
    unique case (q.st)
      TG_RAMP:  lim = T_RAMP;
      TG_PULSE: lim = tg.plen;
      TG_FALL:  lim = T_OFF;
      default:  lim = 8'h00;
    endcase
    done = tick && (8'(q.cnt + 8'h01) >= lim);
    // ramp up, pulse, switch off
    unique case (q.st)
      TG_OFF:   if (tg.go) d.st = TG_RAMP;
      TG_RAMP:  if (done) d.st = TG_PULSE;
      TG_PULSE: if (done) d.st = tg.hold ? TG_HOLD : TG_FALL;
      TG_HOLD: begin
        if (tg.stop) d.st = TG_FALL;
        else if (tg.next) d.st = TG_PULSE;
      end
      TG_FALL:  if (done) d.st = TG_OFF;
    endcase
    if (tg.abort) d.st = TG_OFF;
    if (d.st != q.st) d.cnt = 8'h00;
    else if (tick) d.cnt = 8'(q.cnt + 8'h01);
    d.pgo = (d.st == TG_PULSE) && (q.st != TG_PULSE);
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) q <= '0;
    else q <= d;
  end
  assign tg.st       = q.st;
  assign tg.pulse_go = q.pgo;
endmodule // flash_tgen

/* File: cpu_bus_model.sv */
// cpu_bus_model: bus master on the flash memory address and data buses
// assumes: tasks are called from tb_top; clock shared with the dut
`timescale 1ns/10ps
module cpu_bus_model (
  input  wire logic        i_clk,   // system clock
  input  wire logic [15:0] i_rdata, // memory read data
  output logic      [9:0]  o_mab,   // byte address
  output logic      [15:0] o_wdata, // write data
  output logic             o_rd,    // read strobe
  output logic             o_wr,    // write strobe
  output logic             o_byte,  // byte access
  output logic             o_fetch  // read is a fetch
);
  initial begin
    {o_mab, o_wdata, o_rd, o_wr, o_byte, o_fetch} = '0;
  end
  // one-cycle write; released lines show the inverse, never stale data
  task automatic wr(input logic [9:0] a, input logic [15:0] d,
                    input logic b);
    @(posedge i_clk);
    o_mab <= a;
    o_wdata <= d;
    o_byte <= b;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_mab <= ~a;
    o_wdata <= ~d;
  endtask
  // one-cycle read; data taken in the cycle after the strobe
  task automatic rd(input logic [9:0] a, input logic f,
                    output logic [15:0] d);
    @(posedge i_clk);
    o_mab <= a;
    o_fetch <= f;
    o_byte <= 1'b0;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_fetch <= 1'b0;
    o_mab <= ~a;
    #1 d = i_rdata;
  endtask
endmodule // cpu_bus_model

/* File: tb_top.sv */
// tb_top: self-checking bench for the flash program and erase control
// assumes: timing clocks well below i_clk/2, divider set to 0 or 1
`timescale 1ns/10ps
module tb_top;
  import flash_pkg::*;
  logic        i_clk, i_rst_b, reg_wr, reg_rd;
  logic [1:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [9:0]  mab;
  logic [15:0] mwd, mrd;
  logic        mem_rd, mem_wr, mem_byte, mem_fetch;
  logic        o_stall, o_detached, o_busy, o_wait, o_nmi_req;
  logic        aux_clk, main_clk, sub_clk;
  int          err_count, n_checks, cyc;

  flash_program_erase_control dut (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .o_reg_rdata(reg_rdata), .i_mab(mab), .i_mdb_wdata(mwd),
    .i_mem_rd(mem_rd), .i_mem_wr(mem_wr), .i_mem_byte(mem_byte),
    .i_mem_fetch(mem_fetch), .o_mdb_rdata(mrd), .o_stall(o_stall),
    .o_detached(o_detached), .o_busy(o_busy), .o_wait(o_wait),
    .o_nmi_req(o_nmi_req), .i_aux_clk(aux_clk), .i_main_clk(main_clk),
    .i_submain_clk(sub_clk));
  cpu_bus_model cpu (
    .i_clk(i_clk), .i_rdata(mrd), .o_mab(mab), .o_wdata(mwd),
    .o_rd(mem_rd), .o_wr(mem_wr), .o_byte(mem_byte), .o_fetch(mem_fetch));

  // ----------------------------------------------------------------
  // clocks and hang guard
  // ----------------------------------------------------------------
  initial begin
    {i_clk, aux_clk, main_clk, sub_clk} = '0;
    fork
      forever #20 i_clk = ~i_clk;
      forever #80 aux_clk = ~aux_clk;
      forever #100 main_clk = ~main_clk;
      forever #120 sub_clk = ~sub_clk;
    join_none
  end
  // erases take about 1000 to 1500 cycles each; 40000 leaves ample margin
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rwr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge i_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rrd(input logic [1:0] a, input logic [7:0] e);
    @(posedge i_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge i_clk);
    reg_rd <= 1'b0;
    #1 chk("reg", {8'h00, e}, {8'h00, reg_rdata});
  endtask
  task automatic mrdc(input logic [9:0] a, input logic f,
                      input logic [15:0] e);
    logic [15:0] d;
    cpu.rd(a, f, d);
    chk("mem", e, d);
  endtask
  // sel 0 busy low, 1 wait high, 2 nmi pulse; bounded poll
  task automatic wait_for(input int sel);
    int k;
    for (k = 0; k < 3000; k++) begin
      #1;
      if ((sel == 0 && o_busy === 1'b0) || (sel == 1 && o_wait === 1'b1)
          || (sel == 2 && o_nmi_req === 1'b1)) break;
      @(posedge i_clk);
    end
    chk("wait", 16'h0001, {15'h0000, k < 3000});
  endtask
  task automatic prog(input logic [9:0] a, input logic [15:0] d);
    rwr(2'h0, 8'h40);
    cpu.wr(a, d, 1'b0);
    wait_for(0);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rrd(2'h0, 8'h00);
    rrd(2'h1, 8'h42);
    rrd(2'h2, 8'h10);
    rrd(2'h3, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_all_erase();
    rwr(2'h1, 8'h00);
    rwr(2'h2, 8'h00);
    rwr(2'h0, 8'h06);
    cpu.wr(10'h155, 16'h0000, 1'b0);
    #1 chk("busy", 16'h0003, {14'h0, o_busy, o_detached});
    wait_for(0);
    mrdc(10'h000, 1'b0, ERASED);
    mrdc(10'h3FE, 1'b0, ERASED);
    $display("test all erase done");
  endtask
  task automatic t_program();
    rwr(2'h0, 8'h40);
    cpu.wr(10'h010, 16'h1234, 1'b0);
    mrdc(10'h010, 1'b0, BUSY_READ);
    rrd(2'h2, 8'h05);
    mrdc(10'h012, 1'b1, BUSY_READ);
    chk("stall", 16'h0001, {15'h0, o_stall});
    wait_for(0);
    chk("stall", 16'h0000, {15'h0, o_stall});
    rwr(2'h2, 8'h00);
    mrdc(10'h010, 1'b0, 16'h1234);
    rwr(2'h1, 8'h41);
    rrd(2'h1, 8'h41);
    prog(10'h010, 16'h0F0F);
    mrdc(10'h010, 1'b0, 16'h0204);
    $display("test program done");
  endtask
  task automatic t_byte();
    rwr(2'h1, 8'h80);
    rwr(2'h0, 8'h40);
    cpu.wr(10'h021, 16'h00AB, 1'b1);
    wait_for(0);
    mrdc(10'h020, 1'b0, 16'hABFF);
    $display("test byte done");
  endtask
  task automatic t_invalid();
    rwr(2'h2, 8'h40);
    rwr(2'h0, 8'h00);
    cpu.wr(10'h030, 16'h0000, 1'b0);
    wait_for(2);
    rrd(2'h2, 8'h44);
    rwr(2'h2, 8'h00);
    mrdc(10'h030, 1'b0, ERASED);
    $display("test invalid done");
  endtask
  task automatic t_erase();
    prog(10'h080, 16'h0000);
    prog(10'h300, 16'h0000);
    rwr(2'h0, 8'h02);
    cpu.wr(10'h012, 16'h0000, 1'b0);
    wait_for(0);
    mrdc(10'h010, 1'b0, ERASED);
    mrdc(10'h080, 1'b0, 16'h0000);
    rwr(2'h0, 8'h04);
    cpu.wr(10'h000, 16'h0000, 1'b0);
    wait_for(0);
    mrdc(10'h080, 1'b0, ERASED);
    mrdc(10'h300, 1'b0, 16'h0000);
    $display("test erase done");
  endtask
  task automatic t_block();
    rwr(2'h0, 8'hC0);
    cpu.wr(10'h040, 16'h5555, 1'b0);
    wait_for(1);
    mrdc(10'h044, 1'b0, BUSY_READ);
    cpu.wr(10'h080, 16'h0000, 1'b0);
    rrd(2'h2, 8'h0D);
    rwr(2'h2, 8'h00);
    cpu.wr(10'h042, 16'hAAAA, 1'b0);
    repeat (2) @(posedge i_clk);
    #1 chk("wait", 16'h0000, {15'h0, o_wait});
    wait_for(1);
    rwr(2'h0, 8'h40);
    wait_for(0);
    rrd(2'h2, 8'h00);
    mrdc(10'h040, 1'b0, 16'h5555);
    mrdc(10'h042, 1'b0, 16'hAAAA);
    $display("test block done");
  endtask
  task automatic t_abort();
    rwr(2'h0, 8'h06);
    cpu.wr(10'h000, 16'h0000, 1'b0);
    repeat (20) @(posedge i_clk);
    rwr(2'h2, 8'h20);
    repeat (3) @(posedge i_clk);
    #1 chk("abort", 16'h0000, {14'h0, o_busy, o_detached});
    rrd(2'h2, 8'h00);
    $display("test abort done");
  endtask

  initial begin
    {err_count, n_checks, cyc} = '0;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    i_rst_b = 1'b0;
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1'b1;
    t_reset();
    t_all_erase();
    t_program();
    t_byte();
    t_invalid();
    t_erase();
    t_block();
    t_abort();
    test_done();
  end
endmodule // tb_top
